// *** fdl_params.svh ***
// offsets, field positions, reset values and timing counts for the fast detect block
`ifndef FDL_PARAMS_SVH
`define FDL_PARAMS_SVH

// =====================================================================
// register offsets
`define FDL_ADDR_W 13
`define FDL_OFS_CTRL 13'h104
`define FDL_OFS_CUT 13'h105
`define FDL_OFS_FUT_LO 13'h106
`define FDL_OFS_FUT_HI 13'h107
`define FDL_OFS_FLT_LO 13'h108
`define FDL_OFS_FLT_HI 13'h109
`define FDL_OFS_DWELL_LO 13'h10a
`define FDL_OFS_DWELL_HI 13'h10b
`define FDL_OFS_STATUS 13'h10c

// =====================================================================
// field positions
`define FDL_MODE_MSB 3
`define FDL_MODE_LSB 1
`define FDL_CUT_MSB 2
`define FDL_THR_HI_MSB 4

// =====================================================================
// reset values
`define FDL_RST_MODE 3'h0
`define FDL_RST_CUT 3'h7
`define FDL_RST_FUT 13'h1fff
`define FDL_RST_FLT 13'h0000
`define FDL_RST_DWELL 16'h0001

// =====================================================================
// codes and timing counts
`define FDL_LEVEL_MAX 4'h8
`define FDL_CUT_HOLD_CYC 2
`define FDL_HOLD_LEFT 1'h1

`endif

// *** fdl_pkg.sv ***
// types shared by the fast detect block
package fdl_pkg;

  // =====================================================================
  // fast indication content selector
  typedef enum logic [2:0] {
    FDL_MODE_LEVEL4 = 3'h0,
    FDL_MODE_LEVEL3_OVR = 3'h1,
    FDL_MODE_LEVEL2_OVR_FLT = 3'h2,
    FDL_MODE_LEVEL2_CUT_FLT = 3'h3,
    FDL_MODE_FLAGS = 3'h4,
    FDL_MODE_GAIN = 3'h5,
    FDL_MODE_NONE6 = 3'h6,
    FDL_MODE_NONE7 = 3'h7
  } fdl_mode_t;

  typedef logic [12:0] fdl_mag_t;

endpackage : fdl_pkg

// *** fdl_dwell_timer.sv ***
// consecutive below-threshold dwell counter producing the gain-raise indication
`timescale 1ns/10ps
`include "fdl_params.svh"

module fdl_dwell_timer (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic below,
  input wire logic [15:0] dwell,
  output logic raise
);

  logic [15:0] count_reg;
  logic [15:0] count_next;

  // =====================================================================
  // counter
  always_comb
  begin
    count_next = count_reg;
    if (!below)
    begin
      count_next = 16'h0000;
    end
    else if (count_reg != 16'hffff)
    begin
      // saturates so a long quiet spell never wraps back to zero
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_reg <= 16'h0000;
    end
    else if (clk_en)
    begin
      count_reg <= count_next;
    end
  end

  // current sample plus count_reg earlier ones exceed dwell
  assign raise = below && (count_reg >= dwell);

endmodule : fdl_dwell_timer

// *** fdl_fast_detect.sv ***
// two-channel fast detect indication logic with its threshold register file
`timescale 1ns/10ps
`include "fdl_params.svh"

module fdl_fast_detect (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0] ch0_stage_code,
  input wire logic [11:0] ch0_pipe_data,
  input wire logic ch0_pipe_ovr,
  input wire logic [3:0] ch1_stage_code,
  input wire logic [11:0] ch1_pipe_data,
  input wire logic ch1_pipe_ovr,
  output logic [3:0] ch0_fast_indication_bits,
  output logic [3:0] ch1_fast_indication_bits
);

  // =====================================================================
  // register file
  fdl_pkg::fdl_mode_t mode_reg;
  fdl_pkg::fdl_mode_t mode_next;
  logic [2:0] cut_reg;
  logic [2:0] cut_next;
  logic [12:0] fut_reg;
  logic [12:0] fut_next;
  logic [12:0] flt_reg;
  logic [12:0] flt_next;
  logic [15:0] dwell_reg;
  logic [15:0] dwell_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  always_comb
  begin
    mode_next = mode_reg;
    cut_next = cut_reg;
    fut_next = fut_reg;
    flt_next = flt_reg;
    dwell_next = dwell_reg;
    if (reg_wr)
    begin
      if (reg_addr == `FDL_OFS_CTRL)
      begin
        mode_next = fdl_pkg::fdl_mode_t'(reg_wdata[`FDL_MODE_MSB:`FDL_MODE_LSB]);
      end
      else if (reg_addr == `FDL_OFS_CUT)
      begin
        cut_next = reg_wdata[`FDL_CUT_MSB:0];
      end
      else if (reg_addr == `FDL_OFS_FUT_LO)
      begin
        fut_next[7:0] = reg_wdata;
      end
      else if (reg_addr == `FDL_OFS_FUT_HI)
      begin
        fut_next[12:8] = reg_wdata[`FDL_THR_HI_MSB:0];
      end
      else if (reg_addr == `FDL_OFS_FLT_LO)
      begin
        flt_next[7:0] = reg_wdata;
      end
      else if (reg_addr == `FDL_OFS_FLT_HI)
      begin
        flt_next[12:8] = reg_wdata[`FDL_THR_HI_MSB:0];
      end
      else if (reg_addr == `FDL_OFS_DWELL_LO)
      begin
        dwell_next[7:0] = reg_wdata;
      end
      else if (reg_addr == `FDL_OFS_DWELL_HI)
      begin
        dwell_next[15:8] = reg_wdata;
      end
    end
  end

  // =====================================================================
  // read path, reserved bits and unmapped offsets read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd)
    begin
      if (reg_addr == `FDL_OFS_CTRL)
      begin
        rdata_next = {4'h0, mode_reg, 1'b0};
      end
      else if (reg_addr == `FDL_OFS_CUT)
      begin
        rdata_next = {5'h00, cut_reg};
      end
      else if (reg_addr == `FDL_OFS_FUT_LO)
      begin
        rdata_next = fut_reg[7:0];
      end
      else if (reg_addr == `FDL_OFS_FUT_HI)
      begin
        rdata_next = {3'h0, fut_reg[12:8]};
      end
      else if (reg_addr == `FDL_OFS_FLT_LO)
      begin
        rdata_next = flt_reg[7:0];
      end
      else if (reg_addr == `FDL_OFS_FLT_HI)
      begin
        rdata_next = {3'h0, flt_reg[12:8]};
      end
      else if (reg_addr == `FDL_OFS_DWELL_LO)
      begin
        rdata_next = dwell_reg[7:0];
      end
      else if (reg_addr == `FDL_OFS_DWELL_HI)
      begin
        rdata_next = dwell_reg[15:8];
      end
      else if (reg_addr == `FDL_OFS_STATUS)
      begin
        rdata_next = {ch1_fast_indication_bits, ch0_fast_indication_bits};
      end
      else
      begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= fdl_pkg::FDL_MODE_LEVEL4;
      cut_reg <= `FDL_RST_CUT;
      fut_reg <= `FDL_RST_FUT;
      flt_reg <= `FDL_RST_FLT;
      dwell_reg <= `FDL_RST_DWELL;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      mode_reg <= mode_next;
      cut_reg <= cut_next;
      fut_reg <= fut_next;
      flt_reg <= flt_next;
      dwell_reg <= dwell_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // =====================================================================
  // per-channel detection
  logic [3:0] stage_code [2];
  logic [11:0] pipe_data [2];
  logic pipe_ovr [2];
  logic [3:0] fast_reg [2];

  assign stage_code[0] = ch0_stage_code;
  assign stage_code[1] = ch1_stage_code;
  assign pipe_data[0] = ch0_pipe_data;
  assign pipe_data[1] = ch1_pipe_data;
  assign pipe_ovr[0] = ch0_pipe_ovr;
  assign pipe_ovr[1] = ch1_pipe_ovr;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      logic [3:0] level4;
      logic [2:0] level3;
      logic [1:0] level2;
      logic [11:0] abs_data;
      logic [13:0] mag;
      logic cut_now;
      logic fine_above;
      logic fine_below;
      logic gain_raise;
      logic coarse_reg;
      logic coarse_next;
      logic hold_reg;
      logic hold_next;
      logic [3:0] fast_next;

      // stage code clamped so codes above full-scale range never leave
      assign level4 = (stage_code[ch] > `FDL_LEVEL_MAX) ? `FDL_LEVEL_MAX : stage_code[ch];
      // top range folds into 111 so the low eight ranges keep their codes
      assign level3 = level4[3] ? 3'h7 : level4[2:0];
      assign level2 = level3[2:1];

      // magnitude of the twos-complement word; -2048 maps to 2048
      assign abs_data = pipe_data[ch][11] ? (~pipe_data[ch] + 12'h001) : pipe_data[ch];
      // scaled so full scale reads 2^13 against 13-bit thresholds
      assign mag = {abs_data, 2'b00};
      assign fine_above = mag > {1'b0, fut_reg};
      assign fine_below = mag < {1'b0, flt_reg};
      assign cut_now = level3 > cut_reg;

      // coarse-above with minimum assertion time
      always_comb
      begin
        coarse_next = cut_now;
        hold_next = 1'b0;
        if (cut_now && !coarse_reg)
        begin
          hold_next = `FDL_HOLD_LEFT;
        end
        else if (coarse_reg && hold_reg)
        begin
          coarse_next = 1'b1;
          hold_next = 1'b0;
        end
      end

      fdl_dwell_timer u_dwell (
        .mclk(mclk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .below(fine_below),
        .dwell(dwell_reg),
        .raise(gain_raise)
      );

      // content selector
      always_comb
      begin
        case (mode_reg)
          fdl_pkg::FDL_MODE_LEVEL4: fast_next = level4;
          fdl_pkg::FDL_MODE_LEVEL3_OVR: fast_next = {level3, pipe_ovr[ch]};
          fdl_pkg::FDL_MODE_LEVEL2_OVR_FLT: fast_next = {level2, pipe_ovr[ch], fine_below};
          fdl_pkg::FDL_MODE_LEVEL2_CUT_FLT: fast_next = {level2, coarse_next, fine_below};
          fdl_pkg::FDL_MODE_FLAGS:
            fast_next = {pipe_ovr[ch], coarse_next, fine_above, fine_below};
          // gain-lower is the coarse-above flag itself
          fdl_pkg::FDL_MODE_GAIN:
            fast_next = {pipe_ovr[ch], fine_above, gain_raise, coarse_next};
          default: fast_next = 4'h0;
        endcase
      end

      // one register stage between the sampled code and the pins
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          coarse_reg <= 1'b0;
          hold_reg <= 1'b0;
          fast_reg[ch] <= 4'h0;
        end
        else if (clk_en)
        begin
          coarse_reg <= coarse_next;
          hold_reg <= hold_next;
          fast_reg[ch] <= fast_next;
        end
      end
    end
  endgenerate

  assign ch0_fast_indication_bits = fast_reg[0];
  assign ch1_fast_indication_bits = fast_reg[1];

endmodule : fdl_fast_detect

// *** fdl_fast_detect_asserts.sv ***
// assertion checker for the fast detect block
`timescale 1ns/10ps
module fdl_fast_detect_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic [3:0] ch0_stage_code,
  input wire logic ch0_pipe_ovr,
  input wire logic [3:0] ch1_stage_code,
  input wire logic [3:0] ch0_fast_indication_bits,
  input wire logic [3:0] ch1_fast_indication_bits
);
  // =====================================================================
  // shadow of mode and coarse threshold
  logic [2:0] mode_reg, mode_next, cut_reg, cut_next;
  logic [3:0] f0, f1;
  assign f0 = ch0_fast_indication_bits;
  assign f1 = ch1_fast_indication_bits;
  always_comb
  begin
    mode_next = mode_reg;
    cut_next = cut_reg;
    if (clk_en && reg_wr && reg_addr == 13'h104)
      mode_next = reg_wdata[3:1];
    if (clk_en && reg_wr && reg_addr == 13'h105)
      cut_next = reg_wdata[2:0];
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= 3'h0;
      cut_reg <= 3'h7;
    end
    else
    begin
      mode_reg <= mode_next;
      cut_reg <= cut_next;
    end
  end
  function automatic logic [2:0] lv3(input logic [3:0] c);
    lv3 = (c > 4'h7) ? 3'h7 : c[2:0];
  endfunction : lv3
  // =====================================================================
  // properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  a_read_answer: assert property (clk_en && reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  a_level_code: assert property (clk_en && mode_reg == 3'h0 && ch0_stage_code <= 4'h8
    |=> f0 == $past(ch0_stage_code)) else $error("level code wrong");
  a_level_clamp: assert property (clk_en && mode_reg == 3'h0 && ch0_stage_code > 4'h8
    |=> f0 == 4'h8) else $error("level code not clamped");
  a_level3_ovr: assert property (clk_en && mode_reg == 3'h1
    |=> f0 == {lv3($past(ch0_stage_code)), $past(ch0_pipe_ovr)}) else $error("mode 1 wrong");
  a_level2_bits: assert property (clk_en && mode_reg inside {3'h2, 3'h3}
    |=> {1'b0, f0[3:2]} == (lv3($past(ch0_stage_code)) >> 1)) else $error("level2 wrong");
  a_flag_ovr: assert property (clk_en && mode_reg inside {3'h4, 3'h5}
    |=> f0[3] == $past(ch0_pipe_ovr)) else $error("overrange bit wrong");
  a_coarse_set: assert property (clk_en && mode_reg == 3'h4 && lv3(ch1_stage_code) > cut_reg
    |=> f1[2]) else $error("coarse flag missing");
  a_coarse_hold: assert property (clk_en && mode_reg == 3'h4 && $past(mode_reg) == 3'h4
    && $past(mode_reg, 2) == 3'h4 && $rose(f0[2]) |=> f0[2]) else $error("coarse hold short");
  a_gain_lower: assert property (clk_en && mode_reg == 3'h5 && lv3(ch1_stage_code) > cut_reg
    |=> f1[0]) else $error("gain lower missing");
  a_unused_low: assert property (clk_en && mode_reg[2:1] == 2'b11
    |=> f0 == 4'h0 && f1 == 4'h0) else $error("unused mode not low");
endmodule : fdl_fast_detect_asserts

bind fdl_fast_detect fdl_fast_detect_asserts u_fdl_fast_detect_asserts (.mclk(mclk),
  .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .ch0_stage_code(ch0_stage_code),
  .ch0_pipe_ovr(ch0_pipe_ovr), .ch1_stage_code(ch1_stage_code),
  .ch0_fast_indication_bits(ch0_fast_indication_bits),
  .ch1_fast_indication_bits(ch1_fast_indication_bits));

// *** fdl_agc_model.sv ***
// gain control logic model sampling one channel's fast bits
`timescale 1ns/10ps
module fdl_agc_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [3:0] fast_bits,
  output logic [3:0] seen
);
  // =====================================================================
  // sampling register, frozen with the converter clock enable
  logic [3:0] seen_reg, seen_next;
  assign seen = seen_reg;
  always_comb
  begin
    seen_next = clk_en ? fast_bits : seen_reg;
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      seen_reg <= 4'h0;
    else
      seen_reg <= seen_next;
  end
endmodule : fdl_agc_model

// *** fdl_fast_detect_tb.sv ***
// self-checking testbench for the fast detect block
`timescale 1ns/10ps
`include "fdl_params.svh"
module fdl_fast_detect_tb;
  logic mclk, reg_rvalid;
  logic arst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ch0_pipe_ovr = 1'b0;
  logic ch1_pipe_ovr = 1'b0;
  logic [12:0] reg_addr = 13'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] ch0_stage_code = 4'h0, ch1_stage_code = 4'h8;
  logic [11:0] ch0_pipe_data = 12'h000, ch1_pipe_data = 12'h7ff;
  logic [3:0] f0, f1, seen, e1;
  logic [2:0] cut = 3'h7;
  logic [12:0] fut, flt;
  int error_cnt = 0;
  int checks = 0;
  logic [7:0] rst_v [0:7] = '{8'h00, 8'h07, 8'hff, 8'h1f, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [3:0] sc [0:2] = '{4'h9, 4'h3, 4'h0};
  logic [11:0] sd [0:2] = '{12'hbff, 12'h040, 12'hfc1};
  logic so [0:2] = '{1'b1, 1'b0, 1'b0};

  fdl_fast_detect u_fdl_fast_detect (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ch0_stage_code(ch0_stage_code),
    .ch0_pipe_data(ch0_pipe_data), .ch0_pipe_ovr(ch0_pipe_ovr), .ch1_stage_code(ch1_stage_code),
    .ch1_pipe_data(ch1_pipe_data), .ch1_pipe_ovr(ch1_pipe_ovr),
    .ch0_fast_indication_bits(f0), .ch1_fast_indication_bits(f1));
  fdl_agc_model u_fdl_agc_model (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .fast_bits(f0), .seen(seen));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // =====================================================================
  // expected fast bits from inputs held steady
  function automatic logic [3:0] expf(input logic [2:0] m, input logic [3:0] c,
    input logic [11:0] d, input logic o, input logic hc, input logic r);
    logic [3:0] l4;
    logic [2:0] l3;
    logic [13:0] mg;
    l4 = (c > 4'h8) ? 4'h8 : c;
    l3 = (l4 > 4'h7) ? 3'h7 : l4[2:0];
    mg = {(d[11] ? -d : d), 2'b00};
    case (m)
      3'h0: expf = l4;
      3'h1: expf = {l3, o};
      3'h2: expf = {l3[2:1], o, mg < {1'b0, flt}};
      3'h3: expf = {l3[2:1], (l3 > cut) | hc, mg < {1'b0, flt}};
      3'h4: expf = {o, (l3 > cut) | hc, mg > {1'b0, fut}, mg < {1'b0, flt}};
      3'h5: expf = {o, mg > {1'b0, fut}, r, l3 > cut};
      default: expf = 4'h0;
    endcase
  endfunction : expf

  // =====================================================================
  // access tasks
  task wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [12:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    checks++;
    if (reg_rvalid !== 1'b1 || reg_rdata !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: read %h gave %h", $time, a, reg_rdata);
    end
  endtask : rd
  task cyc(input logic [3:0] c, input logic [11:0] d, input logic o);
    @(posedge mclk);
    ch0_stage_code <= c;
    ch0_pipe_data <= d;
    ch0_pipe_ovr <= o;
    #1;
  endtask : cyc
  task chk(input logic [3:0] e0, input logic [3:0] e);
    checks++;
    if (f0 !== e0 || f1 !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: fast bits %h %h", $time, f0, f1);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  initial
  begin
    #200000;
    error_cnt++;
    conclude();
  end

  // =====================================================================
  // test sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(13'h104 + 13'(i), rst_v[i]);
    rd(13'h1ff, 8'h00);
    wr(13'h104, 8'h0f);
    rd(13'h104, 8'h0e);
    cut = 3'h4;
    fut = 13'h1000;
    flt = 13'h0100;
    wr(13'h105, 8'h04);
    wr(13'h107, 8'h10);
    wr(13'h106, 8'h00);
    wr(13'h109, 8'h01);
    wr(13'h10b, 8'h01);
    wr(13'h10a, 8'h00);
    rd(13'h107, 8'h10);
    $display("test registers done");
    for (int m = 0; m < 8; m++)
    begin
      wr(13'h104, {4'h0, m[2:0], 1'b0});
      e1 = expf(m[2:0], 4'h8, 12'h7ff, 1'b0, 1'b0, 1'b0);
      for (int s = 0; s < 3; s++)
      begin
        repeat (4) cyc(sc[s], sd[s], so[s]);
        chk(expf(m[2:0], sc[s], sd[s], so[s], 1'b0, 1'b0), e1);
      end
    end
    $display("test modes done");
    wr(13'h104, 8'h08);
    e1 = expf(3'h4, 4'h8, 12'h7ff, 1'b0, 1'b0, 1'b0);
    repeat (3) cyc(4'h0, 12'h400, 1'b0);
    cyc(4'h5, 12'h400, 1'b0);
    cyc(4'h0, 12'h400, 1'b0);
    chk(expf(3'h4, 4'h5, 12'h400, 1'b0, 1'b0, 1'b0), e1);
    cyc(4'h0, 12'h400, 1'b0);
    chk(expf(3'h4, 4'h0, 12'h400, 1'b0, 1'b1, 1'b0), e1);
    cyc(4'h0, 12'h400, 1'b0);
    chk(expf(3'h4, 4'h0, 12'h400, 1'b0, 1'b0, 1'b0), e1);
    $display("test coarse hold done");
    wr(13'h10a, 8'h03);
    wr(13'h10b, 8'h00);
    wr(13'h104, 8'h0a);
    e1 = expf(3'h5, 4'h8, 12'h7ff, 1'b0, 1'b0, 1'b0);
    cyc(4'h0, 12'hfc1, 1'b0);
    for (int i = 1; i < 6; i++)
    begin
      cyc(4'h0, 12'hfc1, 1'b0);
      chk(expf(3'h5, 4'h0, 12'hfc1, 1'b0, 1'b0, i >= 4), e1);
    end
    // status offset mirrors both channels' fast bits, ch1 in the upper nibble
    rd(`FDL_OFS_STATUS, {e1, 4'h2});
    @(posedge mclk);
    clk_en <= 1'b0;
    repeat (2) cyc(4'h9, 12'h7ff, 1'b1);
    chk(4'h2, e1);
    checks++;
    if (seen !== 4'h2)
    begin
      error_cnt++;
      $display("wrong value at %0t: sampled %h", $time, seen);
    end
    @(posedge mclk);
    clk_en <= 1'b1;
    $display("test dwell and freeze done");
    conclude();
  end
endmodule : fdl_fast_detect_tb
